// File: hw/dic_pkg.sv
package dic_pkg;
  // widths
  localparam int NUM_IN = 16;
  localparam int NUM_AUX = 8;
  localparam int WORD_W = 32;
  localparam int CODE_W = 8;
  localparam int ROUTE_ENTRIES = 36;
  localparam int STATE_BITS = 32;

  // table select on the object access port
  localparam logic SEL_CONTROL = 1'b0;
  localparam logic SEL_ROUTING = 1'b1;

  // input control array subindices
  localparam logic [7:0] SUB_HIGHEST = 8'h00;
  localparam logic [7:0] SUB_SFE = 8'h01;
  localparam logic [7:0] SUB_INV = 8'h02;
  localparam logic [7:0] SUB_FRC_EN = 8'h03;
  localparam logic [7:0] SUB_FRC_VAL = 8'h04;
  localparam logic [7:0] SUB_RAW = 8'h05;
  localparam logic [7:0] SUB_THR = 8'h06;
  localparam logic [7:0] SUB_DIFF = 8'h07;
  localparam logic [7:0] SUB_ROUTE_EN = 8'h08;

  // read-only entry counts
  localparam logic [7:0] CTRL_HIGHEST = 8'h08;
  localparam logic [7:0] ROUTE_HIGHEST = 8'h24;

  // reset values
  localparam logic [31:0] SFE_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] CODE_RST = 8'h00;

  // special function bit positions
  localparam int SF_NEG_LIMIT = 0;
  localparam int SF_POS_LIMIT = 1;
  localparam int SF_HOME = 2;

  // routing enable bit
  localparam int ROUTE_EN_BIT = 0;

  // routing source code layout
  localparam int CODE_INV_BIT = 7;
  localparam logic [6:0] SRC_CONST = 7'h00;
  localparam logic [6:0] SRC_PHYS_LO = 7'h01;
  localparam logic [6:0] SRC_PHYS_HI = 7'h10;
  localparam logic [6:0] SRC_AUX_LO = 7'h41;
  localparam logic [6:0] SRC_AUX_HI = 7'h48;

  // inputs that serve as clock and direction in clock-direction mode
  localparam logic [15:0] CLKDIR_MASK = 16'h0003;
endpackage

// File: hw/dic_sync.sv
`timescale 1ns/1ps
module dic_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] d_in, // asynchronous level
  output logic [W-1:0] q_out // synchronised level
);
  logic [W-1:0] meta_r;

  // meta_r is read by q_out only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

// File: hw/dic_route_sel.sv
`timescale 1ns/1ps
module dic_route_sel (
  input wire logic [dic_pkg::CODE_W-1:0] code, // routing source code
  input wire logic [dic_pkg::NUM_IN-1:0] cond_in, // conditioned physical inputs
  input wire logic [dic_pkg::NUM_AUX-1:0] aux_in, // hall, encoder, usb, link status
  output logic bit_out // selected state bit
);
  logic [6:0] src;
  logic sel;

  always_comb begin
    src = code[6:0];
    sel = 1'b0;
    // 00 gives 0, and with the invert bit 80 gives 1
    if (src >= dic_pkg::SRC_PHYS_LO && src <= dic_pkg::SRC_PHYS_HI) begin
      sel = cond_in[4'(src - dic_pkg::SRC_PHYS_LO)];
    end else if (src >= dic_pkg::SRC_AUX_LO && src <= dic_pkg::SRC_AUX_HI) begin
      sel = aux_in[3'(src - dic_pkg::SRC_AUX_LO)];
    end
    // unknown codes read as constant 0 before the invert bit
    bit_out = sel ^ code[dic_pkg::CODE_INV_BIT];
  end
endmodule

// File: hw/dic_top.sv
`timescale 1ns/1ps
// Behaviour
// - special function enable bit 0 disables, 1 enables that input's function
// - enable bits 16 to 31 change nothing
// - only bits 0,1,2 matter: negative limit, positive limit, home
// - inversion 0 passes a high as 1; inversion 1 turns it to 0
// - inversion covers normal and special inputs, not clock/direction inputs
// - bit n of inversion and force registers controls input n+1
// - force enable 1 replaces the pin level with the software value
// - a forced input reports its force value bit XOR its inversion bit
// - raw value register shows pin levels before forcing and inversion
// - threshold bit 0 selects 5 V, 1 selects 24 V
// - control array reports read-only highest subindex 08
// - a routing table chooses the source of each state word bit
// - routing entry k (1 to 32) feeds state word bit k-1
// - codes: 00 zero, 01-10 inputs, 80 one, 81-90 inverted inputs
module dic_top (
  input wire logic clk, // system clock, 50 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic [dic_pkg::NUM_IN-1:0] din_pin, // physical digital inputs
  input wire logic [dic_pkg::NUM_AUX-1:0] aux_pin, // hall u/v/w, enc a/b/idx, usb, link
  input wire logic clkdir_mode, // inputs serve as clock/direction
  input wire logic acc_sel, // 0 control array, 1 routing table
  input wire logic [7:0] acc_sub, // subindex
  input wire logic acc_wr, // write strobe
  input wire logic acc_rd, // read strobe
  input wire logic [dic_pkg::WORD_W-1:0] acc_wdata, // write data
  output logic [dic_pkg::WORD_W-1:0] acc_rdata, // read data
  output logic acc_ack, // access done pulse
  output logic [dic_pkg::STATE_BITS-1:0] input_state_word, // digital input state
  output logic neg_limit, // negative limit switch active
  output logic pos_limit, // positive limit switch active
  output logic home_sw, // home switch active
  output logic [dic_pkg::NUM_IN-1:0] thr_24v, // 1 selects 24 V threshold
  output logic [dic_pkg::NUM_IN-1:0] diff_sel // differential input select
);
  logic [dic_pkg::NUM_IN-1:0] raw;
  logic [dic_pkg::NUM_AUX-1:0] aux_s;
  logic [31:0] sfe_r;
  logic [31:0] inv_r;
  logic [31:0] frc_en_r;
  logic [31:0] frc_val_r;
  logic [31:0] thr_r;
  logic [31:0] diff_r;
  logic [31:0] route_en_r;
  logic [dic_pkg::CODE_W-1:0] route_tab_r [dic_pkg::ROUTE_ENTRIES];
  logic [dic_pkg::NUM_IN-1:0] forced;
  logic [dic_pkg::NUM_IN-1:0] inv_eff;
  logic [dic_pkg::NUM_IN-1:0] cond;
  logic [dic_pkg::STATE_BITS-1:0] routed;
  logic [dic_pkg::STATE_BITS-1:0] state_nxt;
  logic [dic_pkg::WORD_W-1:0] rdata_nxt;
  logic wr_ctrl;
  logic wr_route;
  logic sub_in_route;

  // pins are asynchronous to clk
  dic_sync #(.W(dic_pkg::NUM_IN)) u_sync_din (
    .clk(clk),
    .arst_n(arst_n),
    .d_in(din_pin),
    .q_out(raw)
  );

  dic_sync #(.W(dic_pkg::NUM_AUX)) u_sync_aux (
    .clk(clk),
    .arst_n(arst_n),
    .d_in(aux_pin),
    .q_out(aux_s)
  );

  // conditioning chain
  always_comb begin
    // bit n of each register acts on input n+1
    forced = (frc_en_r[15:0] & frc_val_r[15:0]) | (~frc_en_r[15:0] & raw);
    inv_eff = inv_r[15:0];
    if (clkdir_mode) begin
      inv_eff = inv_r[15:0] & ~dic_pkg::CLKDIR_MASK;
    end
    cond = forced ^ inv_eff;
  end

  // one source selector per state word bit
  genvar gi;
  generate
    for (gi = 0; gi < dic_pkg::STATE_BITS; gi++) begin : g_route
      // entry gi+1 is stored at array index gi
      dic_route_sel u_sel (
        .code(route_tab_r[gi]),
        .cond_in(cond),
        .aux_in(aux_s),
        .bit_out(routed[gi])
      );
    end
  endgenerate

  // without routing the conditioned inputs land directly in the low bits
  always_comb begin
    if (route_en_r[dic_pkg::ROUTE_EN_BIT]) begin
      state_nxt = routed;
    end else begin
      state_nxt = {{(dic_pkg::STATE_BITS - dic_pkg::NUM_IN){1'b0}}, cond};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_state_word <= dic_pkg::WORD_RST;
    end else begin
      input_state_word <= state_nxt;
    end
  end

  // special functions; enable bits above 2 are never looked at
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      neg_limit <= 1'b0;
      pos_limit <= 1'b0;
      home_sw <= 1'b0;
    end else begin
      neg_limit <= sfe_r[dic_pkg::SF_NEG_LIMIT] & cond[dic_pkg::SF_NEG_LIMIT];
      pos_limit <= sfe_r[dic_pkg::SF_POS_LIMIT] & cond[dic_pkg::SF_POS_LIMIT];
      home_sw <= sfe_r[dic_pkg::SF_HOME] & cond[dic_pkg::SF_HOME];
    end
  end

  // analog front end selects
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_24v <= '0;
      diff_sel <= '0;
    end else begin
      thr_24v <= thr_r[15:0];
      diff_sel <= diff_r[15:0];
    end
  end

  // write decode
  assign wr_ctrl = acc_wr && (acc_sel == dic_pkg::SEL_CONTROL);
  assign wr_route = acc_wr && (acc_sel == dic_pkg::SEL_ROUTING);
  assign sub_in_route = (acc_sub != 8'h00) && (acc_sub <= dic_pkg::ROUTE_HIGHEST);

  // control array; raw value and highest subindex ignore writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfe_r <= dic_pkg::SFE_RST;
      inv_r <= dic_pkg::WORD_RST;
      frc_en_r <= dic_pkg::WORD_RST;
      frc_val_r <= dic_pkg::WORD_RST;
      thr_r <= dic_pkg::WORD_RST;
      diff_r <= dic_pkg::WORD_RST;
      route_en_r <= dic_pkg::WORD_RST;
    end else if (wr_ctrl) begin
      case (acc_sub)
        // upper enable bits are stored for readback only
        dic_pkg::SUB_SFE: sfe_r <= acc_wdata;
        dic_pkg::SUB_INV: inv_r <= acc_wdata;
        dic_pkg::SUB_FRC_EN: frc_en_r <= acc_wdata;
        dic_pkg::SUB_FRC_VAL: frc_val_r <= acc_wdata;
        dic_pkg::SUB_THR: thr_r <= acc_wdata;
        dic_pkg::SUB_DIFF: diff_r <= acc_wdata;
        dic_pkg::SUB_ROUTE_EN: route_en_r <= acc_wdata;
        default: begin
        end
      endcase
    end
  end

  // routing table entries 1 to 36
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < dic_pkg::ROUTE_ENTRIES; i++) begin
        route_tab_r[i] <= dic_pkg::CODE_RST;
      end
    end else if (wr_route && sub_in_route) begin
      route_tab_r[6'(acc_sub - 8'h01)] <= acc_wdata[dic_pkg::CODE_W-1:0];
    end
  end

  // read mux; unmapped subindices read zero
  always_comb begin
    rdata_nxt = '0;
    if (acc_sel == dic_pkg::SEL_CONTROL) begin
      case (acc_sub)
        dic_pkg::SUB_HIGHEST: rdata_nxt = {24'h000000, dic_pkg::CTRL_HIGHEST};
        dic_pkg::SUB_SFE: rdata_nxt = sfe_r;
        dic_pkg::SUB_INV: rdata_nxt = inv_r;
        dic_pkg::SUB_FRC_EN: rdata_nxt = frc_en_r;
        dic_pkg::SUB_FRC_VAL: rdata_nxt = frc_val_r;
        dic_pkg::SUB_RAW: rdata_nxt = {16'h0000, raw};
        dic_pkg::SUB_THR: rdata_nxt = thr_r;
        dic_pkg::SUB_DIFF: rdata_nxt = diff_r;
        dic_pkg::SUB_ROUTE_EN: rdata_nxt = route_en_r;
        default: rdata_nxt = '0;
      endcase
    end else if (acc_sub == 8'h00) begin
      rdata_nxt = {24'h000000, dic_pkg::ROUTE_HIGHEST};
    end else if (sub_in_route) begin
      rdata_nxt = {24'h000000, route_tab_r[6'(acc_sub - 8'h01)]};
    end
  end

  // answer one cycle after the strobe; rdata holds until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_rdata <= '0;
      acc_ack <= 1'b0;
    end else begin
      acc_ack <= acc_rd | acc_wr;
      if (acc_rd) begin
        acc_rdata <= rdata_nxt;
      end
    end
  end
endmodule

// File: verification/dic_switch_model.sv
`timescale 1ns/1ps
module dic_switch_model (
  input wire logic clk, // system clock
  input wire logic [15:0] want_din, // requested contact levels
  input wire logic [7:0] want_aux, // requested sensor levels
  output logic [15:0] din_pin, // switch contacts
  output logic [7:0] aux_pin // sensor lines
);
  // contacts move mid-cycle, never on the sampling edge
  always @(negedge clk) begin
    din_pin <= want_din;
    aux_pin <= want_aux;
  end
endmodule

// File: verification/dic_top_asserts.sv
`timescale 1ns/1ps
module dic_top_asserts (
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire logic acc_sel, // table
  input wire logic [7:0] acc_sub, // subindex
  input wire logic acc_wr, // write
  input wire logic acc_rd, // read
  input wire logic [31:0] acc_wdata, // wdata
  input wire logic [31:0] acc_rdata, // rdata
  input wire logic acc_ack, // ack
  input wire logic neg_limit, // limit
  input wire logic pos_limit, // limit
  input wire logic home_sw, // home
  input wire logic [15:0] thr_24v // threshold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic sfe_w;
  logic thr_w;
  assign sfe_w = acc_wr && !acc_sel && acc_sub == 8'h01;
  assign thr_w = acc_wr && !acc_sel && acc_sub == 8'h06;
  ack_follows_a: assert property ((acc_rd || acc_wr) |=> acc_ack) else $error("no ack");
  ack_cause_a: assert property (acc_ack |-> $past(acc_rd || acc_wr)) else $error("stray ack");
  highest_read_a: assert property (
    acc_rd && !acc_wr && !acc_sel && acc_sub == 8'h00 |=> acc_rdata == 32'h0000_0008)
    else $error("bad count");
  thr_copy_a: assert property (
    thr_w ##1 !thr_w |=> thr_24v == $past(acc_wdata[15:0], 2)) else $error("thr copy");
  thr_hold_a: assert property (
    !thr_w ##1 !thr_w |=> $stable(thr_24v)) else $error("thr moved");
  neg_off_a: assert property (
    sfe_w && !acc_wdata[0] ##1 !sfe_w |=> !neg_limit) else $error("neg on");
  pos_off_a: assert property (
    sfe_w && !acc_wdata[1] ##1 !sfe_w |=> !pos_limit) else $error("pos on");
  home_off_a: assert property (
    sfe_w && !acc_wdata[2] ##1 !sfe_w |=> !home_sw) else $error("home on");
endmodule
bind dic_top dic_top_asserts u_chk (.*);

// File: verification/dic_top_bench.sv
`timescale 1ns/1ps
module dic_top_bench;
  logic clk = 0, arst_n = 0, clkdir_mode = 0, acc_sel = 0, acc_wr = 0, acc_rd = 0;
  logic [7:0] acc_sub = 0, want_aux = 0, aux_pin, rt [1:36];
  logic [15:0] want_din = 0, din_pin, thr_24v, diff_sel;
  logic [31:0] acc_wdata = 0, acc_rdata, input_state_word, r, m [1:8];
  logic acc_ack, neg_limit, pos_limit, home_sw;
  int errors = 0, n_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  dic_switch_model u_sw (.*);
  dic_top u_dut (.*);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic acc(logic s, logic [7:0] a, logic w, logic [31:0] d);
    @(negedge clk);
    acc_sel = s;
    acc_sub = a;
    acc_wr = w;
    acc_rd = !w;
    acc_wdata = d;
    @(negedge clk);
    chk("ack", {31'h0, acc_ack}, 32'h1);
    r = acc_rdata;
    acc_wr = 0;
    acc_rd = 0;
  endtask
  // writes to the raw readback are refused, so the model keeps it out
  task automatic wreg(int a, logic [31:0] d);
    acc(0, a[7:0], 1, d);
    if (a != 5) m[a] = d;
  endtask
  function automatic logic [15:0] cond();
    logic [15:0] lv;
    lv = (want_din & ~m[3][15:0]) | (m[4][15:0] & m[3][15:0]);
    return lv ^ (m[2][15:0] & (clkdir_mode ? 16'hFFFC : 16'hFFFF));
  endfunction
  function automatic logic route(logic [7:0] c);
    logic [15:0] cv;
    logic b;
    cv = cond();
    b = 0;
    if (c[6:0] >= 7'h01 && c[6:0] <= 7'h10) b = cv[c[6:0] - 7'h01];
    if (c[6:0] >= 7'h41 && c[6:0] <= 7'h48) b = want_aux[c[6:0] - 7'h41];
    return b ^ c[7];
  endfunction
  function automatic logic [7:0] pick(int n);
    int b;
    b = n % 25;
    return (b < 17 ? 8'(b) : 8'(b + 48)) | (n % 50 >= 25 ? 8'h80 : 8'h00);
  endfunction
  task automatic check_out;
    logic [31:0] e;
    logic [15:0] c;
    repeat (5) @(negedge clk);
    c = cond();
    e = {16'h0, c};
    if (m[8][0]) for (int k = 1; k <= 32; k++) e[k-1] = route(rt[k]);
    chk("state", input_state_word, e);
    chk("limits", {home_sw, pos_limit, neg_limit}, m[1][2:0] & c[2:0]);
    chk("thr", {diff_sel, thr_24v}, {m[7][15:0], m[6][15:0]});
    acc(0, 8'h05, 0, 0);
    chk("raw", r, {16'h0, want_din});
  endtask
  initial begin
    void'($urandom(32'hc79c));
    for (int k = 1; k <= 8; k++) m[k] = 0;
    for (int k = 1; k <= 36; k++) rt[k] = 0;
    repeat (5) @(negedge clk);
    arst_n = 1;
    // sub 09 is unmapped and must read as zero
    for (int k = 0; k <= 9; k++) begin
      acc(0, k[7:0], 0, 0);
      chk("ctrl", r, k == 0 ? 32'h8 : 32'h0);
    end
    acc(0, 8'h00, 1, 32'hFFFF_FFFF);
    acc(0, 8'h00, 0, 0);
    chk("highest", r, 32'h8);
    acc(1, 8'h00, 0, 0);
    chk("rt count", r, 32'h24);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      for (int k = 1; k <= 7; k++) wreg(k, $urandom());
      for (int k = 1; k <= 7; k++) begin
        acc(0, k[7:0], 0, 0);
        if (k != 5) chk("reg", r, m[k]);
      end
      want_din = 16'($urandom());
      want_aux = 8'($urandom());
      clkdir_mode = i[0];
      check_out();
    end
    $display("test conditioning done");
    wreg(8, 32'h1);
    for (int i = 0; i < 4; i++) begin
      for (int k = 1; k <= 36; k++) begin
        rt[k] = pick(i * 36 + k);
        acc(1, k[7:0], 1, {24'($urandom()), rt[k]});
      end
      acc(1, 8'h25, 1, 32'hFF);
      acc(1, 8'h25, 0, 0);
      chk("rt over", r, 32'h0);
      acc(1, 8'h02, 0, 0);
      chk("rt entry", r, {24'h0, rt[2]});
      for (int k = 2; k <= 4; k++) wreg(k, $urandom());
      want_din = 16'($urandom());
      want_aux = 8'($urandom());
      check_out();
    end
    $display("test routing done");
    print_verdict();
  end
endmodule
